// ===== hw/bsp_burst_mem.sv
`default_nettype none
`include "bsp_cfg.svh"
module bsp_burst_mem #(
  parameter int DATA_W = `BSP_DATA_W,
  parameter int LANE_W = `BSP_LANE_W,
  parameter int ADDR_W = `BSP_ADDR_W
) (
  input  wire logic                       clk,
  input  wire logic                       wr_en,
  input  wire logic [ADDR_W-1:0]          wr_addr,
  input  wire logic                       wr_beat,
  input  wire logic [DATA_W-1:0]          wr_data,
  input  wire logic [DATA_W/LANE_W-1:0]   wr_mask_n,
  input  wire logic [ADDR_W-1:0]          rd_addr,
  input  wire logic                       rd_beat,
  output logic      [DATA_W-1:0]          rd_data
);
  localparam int NL = DATA_W / LANE_W;
  localparam int NW = 2 ** (ADDR_W + 1);

  genvar l;
  generate
    for (l = 0; l < NL; l++) begin : g_lane
      logic [LANE_W-1:0] cells [NW];
      // lane stored only when its mask is low; all masked stores nothing
      always_ff @(posedge clk) begin
        if (wr_en && !wr_mask_n[l]) begin
          cells[{wr_addr, wr_beat}] <= wr_data[l*LANE_W +: LANE_W];
        end
      end
      // beat 0 is the base word, beat 1 the next word
      assign rd_data[l*LANE_W +: LANE_W] = cells[{rd_addr, rd_beat}];
    end
  endgenerate
endmodule // bsp_burst_mem
`default_nettype wire

// ===== hw/bsp_imp_cal.sv
`default_nettype none
`include "bsp_cfg.svh"
module bsp_imp_cal #(
  parameter int PERIOD = `BSP_CAL_PERIOD
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    hold,
  input  wire logic                    cmp_up,
  output logic      [`BSP_CODE_W-1:0]  code
);
  localparam logic [15:0]            LAST = 16'(PERIOD - 1);
  localparam logic [`BSP_CODE_W-1:0] MAXC = '1;

  bsp_pkg::bsp_cal_s st;
  bsp_pkg::bsp_cal_s next_st;

  always_comb begin
    next_st = st;
    if (!hold) begin
      if (st.cnt == LAST) begin
        next_st.cnt = 16'h0000;
        if (cmp_up && st.code != MAXC) begin
          next_st.code = st.code + 1'b1;
        end else if (!cmp_up && st.code != '0) begin
          next_st.code = st.code - 1'b1;
        end
      end else begin
        next_st.cnt = st.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st.cnt  <= 16'h0000;
      st.code <= `BSP_CODE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign code = st.code;
endmodule // bsp_imp_cal
`default_nettype wire

// ===== hw/bsp_port.sv
// Design decisions made here: register access over APB and the placing of the registers.
`default_nettype none
`include "bsp_cfg.svh"
module bsp_port #(
  parameter int CAL_PERIOD = `BSP_CAL_PERIOD
) (
  input  wire logic                                  pclk,
  input  wire logic                                  presetn,
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [11:0]                           paddr,
  input  wire logic [31:0]                           pwdata,
  output logic      [31:0]                           prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  input  wire logic                                  cmd_load_n,
  input  wire logic                                  cmd_read_nwrite,
  input  wire logic [`BSP_ADDR_W-1:0]                cmd_addr,
  input  wire logic [`BSP_DATA_W-1:0]                dq_in,
  output logic      [`BSP_DATA_W-1:0]                dq_out,
  output logic                                       dq_oe,
  input  wire logic [`BSP_DATA_W/`BSP_LANE_W-1:0]    byte_write_mask_n,
  input  wire logic                                  termination_on,
  output logic                                       dq_term_en,
  input  wire logic [1:0]                            impedance_ref_pin,
  output logic      [`BSP_CODE_W-1:0]                drv_code,
  output logic      [`BSP_CODE_W-1:0]                term_code,
  output logic                                       k_phase
);
  bsp_pkg::bsp_top_s  st;
  bsp_pkg::bsp_top_s  next_st;
  bsp_pkg::bsp_slot_s slot_in;

  logic                    k_edge;
  logic                    wr_en;
  logic                    wr_beat;
  logic [`BSP_ADDR_W-1:0]  wr_addr;
  logic                    rd_hit;
  logic                    rd_beat;
  logic [`BSP_ADDR_W-1:0]  rd_addr;
  logic [`BSP_DATA_W-1:0]  rd_data;
  logic                    rd_near;
  logic                    busy;
  logic                    apb_acc;
  logic [31:0]             status_word;

  // phase 0 marks a primary clock edge, phase 1 a complementary edge
  assign k_edge = !st.phase;

  // command capture on primary edges only
  always_comb begin
    slot_in.cmd  = bsp_pkg::bsp_idle;
    slot_in.addr = '0;
    if (k_edge && !cmd_load_n) begin
      slot_in.addr = cmd_addr;
      if (cmd_read_nwrite) begin
        slot_in.cmd = bsp_pkg::bsp_read;
      end else begin
        slot_in.cmd = bsp_pkg::bsp_write;
      end
    end
  end

  // write beats one and one-and-a-half cycles after the command
  always_comb begin
    wr_en   = 1'b0;
    wr_beat = 1'b0;
    wr_addr = st.sr[`BSP_WR_B0_IDX].addr;
    if (st.sr[`BSP_WR_B0_IDX].cmd == bsp_pkg::bsp_write) begin
      wr_en = 1'b1;
    end else if (st.sr[`BSP_WR_B1_IDX].cmd == bsp_pkg::bsp_write) begin
      wr_en   = 1'b1;
      wr_beat = 1'b1;
      wr_addr = st.sr[`BSP_WR_B1_IDX].addr;
    end
  end

  // read beats two-and-a-half and three cycles after the command
  // array is read half a cycle ahead into rd_hold, so a later write cannot overtake a read
  always_comb begin
    rd_hit  = 1'b0;
    rd_beat = 1'b0;
    rd_addr = st.sr[`BSP_RD_B0_IDX-1].addr;
    if (st.sr[`BSP_RD_B1_IDX-1].cmd == bsp_pkg::bsp_read) begin
      rd_beat = 1'b1;
      rd_addr = st.sr[`BSP_RD_B1_IDX-1].addr;
    end
    if (st.sr[`BSP_RD_B0_IDX].cmd == bsp_pkg::bsp_read) begin
      rd_hit = 1'b1;
    end else if (st.sr[`BSP_RD_B1_IDX].cmd == bsp_pkg::bsp_read) begin
      rd_hit = 1'b1;
    end
  end

  // termination window is half a cycle wider than the read drive on each side
  always_comb begin
    rd_near = 1'b0;
    for (int i = `BSP_TERM_LO_IDX; i <= `BSP_TERM_HI_IDX; i++) begin
      if (st.sr[i].cmd == bsp_pkg::bsp_read) begin
        rd_near = 1'b1;
      end
    end
  end

  always_comb begin
    busy = 1'b0;
    for (int i = 0; i < `BSP_PIPE_N; i++) begin
      if (st.sr[i].cmd != bsp_pkg::bsp_idle) begin
        busy = 1'b1;
      end
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`BSP_ST_DRV_LSB +: `BSP_CODE_W]  = drv_code;
    status_word[`BSP_ST_TERM_LSB +: `BSP_CODE_W] = term_code;
    status_word[`BSP_ST_BUSY]                    = busy;
    status_word[`BSP_ST_TERM_EN]                 = st.term_en;
  end

  assign apb_acc = psel && penable;

  always_comb begin
    next_st       = st;
    next_st.phase = !st.phase;
    next_st.sr[0] = slot_in;
    for (int i = 1; i < `BSP_PIPE_N; i++) begin
      next_st.sr[i] = st.sr[i-1];
    end
    // drive only read beats; idle and write slots release the bus
    next_st.dq_oe  = rd_hit;
    next_st.rd_hold = rd_data;
    next_st.dq_out  = rd_hit ? st.rd_hold : '0;
    next_st.term_en = termination_on && !rd_near;

    // apb slave, one wait state per transfer
    next_st.pready  = apb_acc && !st.pready;
    next_st.pslverr = 1'b0;
    next_st.prdata  = 32'h0000_0000;
    if (apb_acc && !st.pready) begin
      if (paddr == `BSP_REG_CTRL) begin
        next_st.prdata[`BSP_CTRL_HOLD] = st.cal_hold;
      end else if (paddr == `BSP_REG_STATUS) begin
        next_st.prdata = status_word;
      end else begin
        next_st.pslverr = 1'b1;
      end
      if (pwrite) begin
        next_st.prdata = 32'h0000_0000;
      end
    end
    if (apb_acc && st.pready && pwrite && !st.pslverr) begin
      if (paddr == `BSP_REG_CTRL) begin
        next_st.cal_hold = pwdata[`BSP_CTRL_HOLD];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  bsp_burst_mem #(
    .DATA_W (`BSP_DATA_W),
    .LANE_W (`BSP_LANE_W),
    .ADDR_W (`BSP_ADDR_W)
  ) u_mem (
    .clk       (pclk),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_beat   (wr_beat),
    .wr_data   (dq_in),
    .wr_mask_n (byte_write_mask_n),
    .rd_addr   (rd_addr),
    .rd_beat   (rd_beat),
    .rd_data   (rd_data)
  );

  // driver leg and termination leg calibrate independently
  bsp_imp_cal #(
    .PERIOD (CAL_PERIOD)
  ) u_drv_cal (
    .clk    (pclk),
    .rst_n  (presetn),
    .hold   (st.cal_hold),
    .cmp_up (impedance_ref_pin[0]),
    .code   (drv_code)
  );

  bsp_imp_cal #(
    .PERIOD (CAL_PERIOD)
  ) u_term_cal (
    .clk    (pclk),
    .rst_n  (presetn),
    .hold   (st.cal_hold),
    .cmp_up (impedance_ref_pin[1]),
    .code   (term_code)
  );

  assign prdata     = st.prdata;
  assign pready     = st.pready;
  assign pslverr    = st.pslverr;
  assign dq_out     = st.dq_out;
  assign dq_oe      = st.dq_oe;
  assign dq_term_en = st.term_en;
  assign k_phase    = st.phase;
endmodule // bsp_port
`default_nettype wire

// ===== inc/bsp_cfg.svh
// Functional notes
// - each command moves exactly two data beats
// - deselect after read waits for read beats
// - load high ignores command inputs
// - address, load, direction sampled on primary edge
// - load low, direction high means pipelined read
// - second write beat on complementary edge
// - masks sampled with each write beat
// - masked lane keeps its stored contents
// - masks independent in each beat
// - each write address bases a two-beat transfer
// - nybble variant uses same masking scheme
// - free-running counter triggers impedance evaluation; here the counter stops while the CTRL hold bit is set
// - evaluation moves code one step at most
// - termination follows the termination-control input
// - data termination off around read driving
// - drivers off for idle and write slots
// - undriven data pins left to termination
// - all lanes masked in both beats stores nothing
`ifndef BSP_CFG_SVH
`define BSP_CFG_SVH
`define BSP_DATA_W       18
`define BSP_LANE_W       9
`define BSP_ADDR_W       8
`define BSP_CODE_W       5
`define BSP_CODE_RST     5'h10
`define BSP_CAL_PERIOD   8192
`define BSP_PIPE_N       7
`define BSP_WR_B0_IDX    1
`define BSP_WR_B1_IDX    2
`define BSP_RD_B0_IDX    4
`define BSP_RD_B1_IDX    5
`define BSP_TERM_LO_IDX  3
`define BSP_TERM_HI_IDX  6
`define BSP_REG_CTRL     12'h000
`define BSP_REG_STATUS   12'h004
`define BSP_CTRL_HOLD    0
`define BSP_ST_DRV_LSB   0
`define BSP_ST_TERM_LSB  8
`define BSP_ST_BUSY      16
`define BSP_ST_TERM_EN   17
`endif

// ===== inc/bsp_pkg.sv
`default_nettype none
`include "bsp_cfg.svh"
package bsp_pkg;
  typedef enum logic [1:0] {bsp_idle, bsp_read, bsp_write} bsp_cmd_e;

  typedef struct packed {
    bsp_cmd_e                cmd;
    logic [`BSP_ADDR_W-1:0]  addr;
  } bsp_slot_s;

  typedef struct packed {
    logic [15:0]             cnt;
    logic [`BSP_CODE_W-1:0]  code;
  } bsp_cal_s;

  typedef struct packed {
    logic                          phase;
    bsp_slot_s [`BSP_PIPE_N-1:0]   sr;
    logic [`BSP_DATA_W-1:0]        rd_hold;
    logic [`BSP_DATA_W-1:0]        dq_out;
    logic                          dq_oe;
    logic                          term_en;
    logic                          cal_hold;
    logic                          pready;
    logic                          pslverr;
    logic [31:0]                   prdata;
  } bsp_top_s;
endpackage
`default_nettype wire

// ===== tb/bsp_ctrl_model.sv
`default_nettype none
module bsp_ctrl_model (
  input  wire logic        pclk,
  input  wire logic        k_phase,
  input  wire logic        req,
  input  wire logic        rd,
  input  wire logic [7:0]  ra,
  input  wire logic [35:0] wd,
  input  wire logic [3:0]  wm,
  output logic             tk,
  output logic             load_n,
  output logic             rnw,
  output logic      [7:0]  addr,
  output logic      [17:0] dq,
  output logic      [1:0]  bwm
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        pw = 1'b0;
  logic        p1 = 1'b0;
  logic [35:0] wl = '0;
  logic [3:0]  ml = '0;
  logic [17:0] d1 = '0;
  logic [1:0]  h1 = '0;
  initial begin
    {tk, load_n, rnw, addr, dq, bwm} = {2'b01, 1'b0, 8'h00, 18'h00000, 2'b11};
  end
  // command set up before a primary edge, beats follow it
  always @(posedge pclk) begin
    if (k_phase) begin
      tk <= req;
      load_n <= !req;
      rnw <= req ? rd : !rnw;
      addr <= req ? ra : ~addr;
      wl <= wd;
      ml <= wm;
      pw <= req && !rd;
      dq <= pw ? wl[17:0] : ~dq;
      bwm <= pw ? ml[1:0] : ~bwm;
      d1 <= wl[35:18];
      h1 <= ml[3:2];
      p1 <= pw;
    end else begin
      tk <= 1'b0;
      dq <= p1 ? d1 : ~dq;
      bwm <= p1 ? h1 : ~bwm;
    end
  end
endmodule // bsp_ctrl_model
`default_nettype wire

// ===== tb/bsp_monitor.sv
`default_nettype none
`include "bsp_cfg.svh"
module bsp_monitor #(
  parameter int CAL_PERIOD = `BSP_CAL_PERIOD
) (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   cmd_load_n,
  input wire logic                   cmd_read_nwrite,
  input wire logic                   dq_oe,
  input wire logic                   termination_on,
  input wire logic                   dq_term_en,
  input wire logic [`BSP_CODE_W-1:0] drv_code,
  input wire logic [`BSP_CODE_W-1:0] term_code,
  input wire logic                   k_phase
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd_c = !k_phase && !cmd_load_n && cmd_read_nwrite;
  wire logic nr_c = !k_phase && (cmd_load_n || !cmd_read_nwrite);
  logic [15:0] since;
  // cycles since the last driver code change
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) since <= 16'h0000;
    else since <= $changed(drv_code) ? 16'h0000 : since + 16'h0001;
  property p_rd_drv; rd_c |-> ##6 dq_oe [*2]; endproperty
  a_rd_drv: assert property (p_rd_drv) else $error("read beats not driven");
  property p_nr_flt; nr_c |-> ##6 !dq_oe [*2]; endproperty
  a_nr_flt: assert property (p_nr_flt) else $error("driving after idle or write");
  property p_trm_rd; rd_c && termination_on |-> ##5 !dq_term_en [*4]; endproperty
  a_trm_rd: assert property (p_trm_rd) else $error("termination on around read");
  property p_trm_off; !termination_on |=> !dq_term_en; endproperty
  a_trm_off: assert property (p_trm_off) else $error("termination without enable");
  property p_oe_trm; dq_oe |-> !dq_term_en; endproperty
  a_oe_trm: assert property (p_oe_trm) else $error("termination while driving");
  property p_drv_stp; 1'b1 |=> 5'(drv_code - $past(drv_code)) inside {5'h00, 5'h01, 5'h1F}; endproperty
  a_drv_stp: assert property (p_drv_stp) else $error("driver code jumped");
  property p_trm_stp; 1'b1 |=> 5'(term_code - $past(term_code)) inside {5'h00, 5'h01, 5'h1F}; endproperty
  a_trm_stp: assert property (p_trm_stp) else $error("termination code jumped");
  property p_cal_gap; $changed(drv_code) |-> since >= 16'(CAL_PERIOD - 1); endproperty
  a_cal_gap: assert property (p_cal_gap) else $error("evaluation too early");
  c_rd: cover property (rd_c ##6 dq_oe);
  c_wr: cover property (!k_phase && !cmd_load_n && !cmd_read_nwrite);
  c_cal: cover property ($changed(term_code));
endmodule // bsp_monitor
bind bsp_port bsp_monitor #(.CAL_PERIOD(CAL_PERIOD)) u_mon (.pclk, .presetn, .cmd_load_n,
  .cmd_read_nwrite, .dq_oe, .termination_on, .dq_term_en, .drv_code, .term_code, .k_phase);
`default_nettype wire

// ===== tb/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        load_n, rnw, dq_oe, term_on = 0, term_en, kph, req = 0, rd = 0, tk;
  logic [7:0]  caddr, ra = '0;
  logic [17:0] dq_in, dq_out, mem [512], exp_q [$];
  logic [35:0] wd = '0;
  logic [3:0]  wm = '0;
  logic [1:0]  bwm, zref = '0;
  logic [4:0]  drv, trm;
  int          n_mismatch = 0, compares = 0, nbeat = 0, nexp = 0;
  always #25 pclk = ~pclk;
  bsp_port #(.CAL_PERIOD(8)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cmd_load_n(load_n), .cmd_read_nwrite(rnw), .cmd_addr(caddr),
    .dq_in, .dq_out, .dq_oe, .byte_write_mask_n(bwm), .termination_on(term_on), .dq_term_en(term_en),
    .impedance_ref_pin(zref), .drv_code(drv), .term_code(trm), .k_phase(kph));
  bsp_ctrl_model u_ctl (.pclk, .k_phase(kph), .req, .rd, .ra, .wd, .wm, .tk, .load_n, .rnw,
    .addr(caddr), .dq(dq_in), .bwm);
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [17:0] mrg(logic [17:0] o, logic [17:0] d, logic [1:0] m);
    mrg = o;
    if (!m[0]) mrg[8:0] = d[8:0];
    if (!m[1]) mrg[17:9] = d[17:9];
  endfunction
  function automatic logic [35:0] r36();
    return 36'({$urandom(), $urandom()});
  endfunction
  task automatic apb(bit w, logic [11:0] a, logic [31:0] d, output logic [31:0] q, output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 10);
    q = prdata;
    e = pslverr;
    if (pready !== 1'b1) begin n_mismatch++; finish_test(); end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op(bit r, logic [7:0] a, logic [35:0] d, logic [3:0] m);
    int i;
    logic [8:0] w;
    w = {a, 1'b0};
    if (r) begin
      exp_q.push_back(mem[w]);
      exp_q.push_back(mem[w+1]);
      nexp += 2;
    end else begin
      mem[w] = mrg(mem[w], d[17:0], m[1:0]);
      mem[w+1] = mrg(mem[w+1], d[35:18], m[3:2]);
    end
    req <= 1'b1;
    rd <= r;
    ra <= a;
    wd <= d;
    wm <= m;
    i = 0;
    do begin @(posedge pclk); i++; end while (tk !== 1'b1 && i < 20);
    if (tk !== 1'b1) begin n_mismatch++; finish_test(); end
  endtask
  task automatic idle();
    req <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    if (dq_oe === 1'b1) begin
      nbeat++;
      if (exp_q.size() == 0) cmp("read_extra", 32'h00000000, 32'h00000001);
      else cmp("read_data", 32'(exp_q.pop_front()), 32'(dq_out));
    end
  end
  initial begin
    logic [31:0] q;
    logic        e;
    logic [4:0]  c0;
    int          i;
    void'($urandom(70993));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    cmp("drv_code", 32'h00000010, 32'(drv));
    apb(1'b1, 12'h000, 32'h00000001, q, e);
    apb(1'b0, 12'h000, 32'h00000000, q, e);
    cmp("ctrl", 32'h00000001, q);
    apb(1'b0, 12'h004, 32'h00000000, q, e);
    cmp("status", 32'h00001010, q);
    apb(1'b1, 12'h00C, 32'hFFFFFFFF, q, e);
    cmp("unmapped", 32'h00000001, 32'(e));
    zref <= 2'b01;
    c0 = drv;
    repeat (40) @(posedge pclk);
    cmp("hold", 32'(c0), 32'(drv));
    apb(1'b1, 12'h000, 32'h00000000, q, e);
    repeat (60) @(posedge pclk);
    cmp("drv_up", 32'h00000001, 32'(drv > 5'h10));
    cmp("trm_dn", 32'h00000001, 32'(trm < 5'h10));
    $display("test calibration done");
    for (i = 0; i < 16; i++) op(1'b0, 8'(i), r36(), 4'h0);
    term_on <= 1'b1;
    for (i = 0; i < 16; i++) op(1'b0, 8'(i), r36(), 4'(i));
    for (i = 0; i < 16; i++) op(1'b1, 8'(i), r36(), 4'h0);
    $display("test mask table done");
    for (i = 0; i < 60; i++) begin
      case ($urandom_range(2))
        0: op(1'b0, 8'($urandom_range(15)), r36(), 4'($urandom()));
        1: op(1'b1, 8'($urandom_range(15)), r36(), 4'h0);
        default: idle();
      endcase
    end
    op(1'b0, 8'h05, r36(), 4'h0);
    op(1'b1, 8'h05, r36(), 4'h0);
    idle();
    repeat (20) @(posedge pclk);
    $display("test random done");
    cmp("beats", 32'(nexp), 32'(nbeat));
    finish_test();
  end
endmodule // testbench
`default_nettype wire
